// ===== verilog/supv_regs_pkg.sv
// Package: offsets, layouts and reset values of the supervisor register bank
package supv_regs_pkg;
    localparam logic [7:0] OFS_OUT_STATE_A  = 8'h03;
    localparam logic [7:0] OFS_OUT_STATE_B  = 8'h04;
    localparam logic [7:0] OFS_INPUT_LEVELS = 8'h06;
    localparam logic [7:0] OFS_SIG_A        = 8'h0a;
    localparam logic [7:0] OFS_SIG_B        = 8'h0b;
    localparam logic [7:0] OFS_SIG_C        = 8'h0c;
    localparam logic [7:0] OFS_SIG_D        = 8'h0d;
    localparam logic [7:0] OFS_SW_OUT_A     = 8'h0e;
    localparam logic [7:0] OFS_SW_OUT_B     = 8'h0f;
    localparam logic [7:0] OFS_IN_OVERRIDE  = 8'h11;
    localparam logic [7:0] OFS_SOFT_RESET   = 8'h12;
    // Reset values of the writable registers
    localparam logic [7:0] RST_SW_OUT_A     = 8'h04;
    localparam logic [5:0] RST_SW_OUT_B     = 6'h00;
    localparam logic [2:0] RST_IN_OVERRIDE  = 3'h0;
    // Field position and output count
    localparam int         ALERT_EN_BIT     = 2;
    localparam int         NUM_OUTPUTS      = 14;
    // Value seen in unmapped and non-functional positions
    localparam logic [7:0] FILL_ONES        = 8'hff;
    // Length of the internal reset pulse from a soft reset, in cycles
    localparam logic [3:0] SOFT_RST_CYCLES  = 4'h4;
    // Smbus alert response address (7-bit)
    localparam logic [6:0] ALERT_RESP_ADDR  = 7'h0c;
endpackage

// ===== verilog/supv_reset_sync.sv
// Reset synchroniser combining the pin reset with the soft reset request
`timescale 1ns/1ps
module supv_reset_sync
    import supv_regs_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // Soft reset request, one-cycle pulse
    input  wire logic soft_req,
    // Synchronised reset
    output logic      core_rstn
);
    logic [1:0] sync_ff;
    logic [3:0] pulse_cnt_ff;
    logic [3:0] nxt_pulse_cnt;
    logic       pulse_active;

    assign pulse_active  = (pulse_cnt_ff != 4'h0);
    assign nxt_pulse_cnt = soft_req ? SOFT_RST_CYCLES
                         : (pulse_active ? pulse_cnt_ff - 4'h1 : 4'h0);

    // Counter lives on pin reset only, so a soft reset cannot cut itself short
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_cnt_ff <= 4'h0;
        end else begin
            pulse_cnt_ff <= nxt_pulse_cnt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync_ff <= 2'b00;
        end else begin
            sync_ff <= {sync_ff[0], ~pulse_active};
        end
    end

    assign core_rstn = sync_ff[1];
endmodule

// ===== verilog/supv_output_mux.sv
// Per-output source selection between logic array and software bits
`timescale 1ns/1ps
module supv_output_mux
    import supv_regs_pkg::*;
(
    // Sources
    input  wire logic [13:0] array_out,
    input  wire logic [13:0] sw_bits,
    input  wire logic [13:0] use_sw,
    // Alert support on output three
    input  wire logic        alert_mode_setting,
    input  wire logic        alert_enable_low,
    // Drive values
    output logic      [13:0] drive_value
);
    logic [13:0] chosen;
    logic        alert_level;

    assign chosen = (use_sw & sw_bits) | (~use_sw & array_out);
    // Alert line low only while armed and the array pulls it low
    assign alert_level = array_out[2] | alert_enable_low;
    assign drive_value = {chosen[13:3],
                          alert_mode_setting ? alert_level : chosen[2],
                          chosen[1:0]};
endmodule

// ===== verilog/supervisor_io_register_bank.sv
// Register bank of the supply supervisor behind the two-wire interface
//
// Overview of operation
// [R1] 0x06 reads input levels four..one in bits 3:0, upper bits one
// [R2] 0x11 holds array input values four..two in bits 3:1
// [R3] Output status shows the internal drive value, not the pin level
// [R4] 0x03 reports output one, two, then three to eight
// [R5] 0x04 reports outputs nine to fourteen, bits 7:6 one
// [R6] Each output chooses array or software bit by nonvolatile setting
// [R7] 0x0e holds software bits one, two, alert enable, four..eight
// [R8] 0x0f holds software bits nine to fourteen, bits 7:6 one
// [R9] Signature bytes 0x0a..0x0d, lowest address holds lowest byte
// [R10] Any write to 0x12 resets the whole device like the pin
// [R11] In alert mode output three mixes array output and alert enable
// [R12] Master arms alert by writing enable low; array pulls line low
// [R13] Alert response read: device transmits its own slave address
// [R14] Matching transmitted address sets alert enable high, releasing line
// [R15] Master clears the cause then re-arms by writing enable low
// [R16] Non-functional bits always read back as one
// [R17] Override reaches array only when its input mux selects register
// [R18] Writes to read-only or non-functional bits are ignored
`timescale 1ns/1ps
module supervisor_io_register_bank
    import supv_regs_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Register port from the two-wire slave engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Alert response phase from the slave engine
    input  wire logic        ara_done,
    input  wire logic [6:0]  ara_sent_addr,
    input  wire logic [6:0]  own_slave_addr,
    // Digital input pins
    input  wire logic [3:0]  digital_input_pin,
    // Nonvolatile configuration
    input  wire logic [2:0]  input_mux_sel_reg,
    input  wire logic [13:0] output_src_sw,
    input  wire logic        alert_mode_setting,
    input  wire logic [31:0] user_signature,
    // Logic array connections
    input  wire logic [13:0] logic_array_out,
    output logic      [3:0]  logic_array_in,
    // Output pin drive, open drain
    output logic      [13:0] out_pin_o,
    output logic      [13:0] out_pin_oe,
    // Device-wide reset
    output logic             device_rstn
);
    logic        core_rstn;
    logic        soft_req;
    logic [7:0]  sw_out_a_ff;
    logic [5:0]  sw_out_b_ff;
    logic [2:0]  override_ff;
    logic [7:0]  rdata_ff;
    logic [13:0] drive_ff;
    logic [3:0]  inputs_ff;
    logic [7:0]  nxt_sw_out_a;
    logic [5:0]  nxt_sw_out_b;
    logic [2:0]  nxt_override;
    logic [7:0]  nxt_rdata;
    logic [13:0] drive_value;
    logic [13:0] sw_bits;
    logic        wr_sw_a;
    logic        wr_sw_b;
    logic        wr_override;
    logic        alert_release;

    assign soft_req = reg_wr && (reg_addr == OFS_SOFT_RESET); // [R10]

    supv_reset_sync u_rst (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .soft_req  (soft_req),
        .core_rstn (core_rstn)
    );
    assign device_rstn = core_rstn; // [R10]

    // Write decode; read-only offsets have no write path
    assign wr_sw_a     = reg_wr && (reg_addr == OFS_SW_OUT_A); // [R18]
    assign wr_sw_b     = reg_wr && (reg_addr == OFS_SW_OUT_B); // [R18]
    assign wr_override = reg_wr && (reg_addr == OFS_IN_OVERRIDE); // [R18]

    // Release only when our own address went out during the response
    assign alert_release = ara_done
                        && (ara_sent_addr == own_slave_addr); // [R13] [R14]

    // Hardware release wins over a simultaneous software arm
    always_comb begin
        nxt_sw_out_a = wr_sw_a ? reg_wdata : sw_out_a_ff; // [R7] [R12] [R15]
        if (alert_release) begin
            nxt_sw_out_a[ALERT_EN_BIT] = 1'b1; // [R14]
        end
    end
    assign nxt_sw_out_b = wr_sw_b ? reg_wdata[5:0] : sw_out_b_ff; // [R8]
    assign nxt_override = wr_override ? reg_wdata[3:1]
                                      : override_ff; // [R2] [R18]

    always_ff @(posedge sys_clk or negedge core_rstn) begin
        if (!core_rstn) begin
            sw_out_a_ff <= RST_SW_OUT_A;
            sw_out_b_ff <= RST_SW_OUT_B;
            override_ff <= RST_IN_OVERRIDE;
        end else begin
            sw_out_a_ff <= nxt_sw_out_a;
            sw_out_b_ff <= nxt_sw_out_b;
            override_ff <= nxt_override;
        end
    end

    // Software bit per output; slot three is held at one, as register bit 2 is the alert enable, not a data bit
    assign sw_bits = {sw_out_b_ff, sw_out_a_ff[7:3],
                      1'b1, sw_out_a_ff[1:0]}; // [R7] [R8]

    supv_output_mux u_mux (
        .array_out          (logic_array_out),
        .sw_bits            (sw_bits),
        .use_sw             (output_src_sw),
        .alert_mode_setting (alert_mode_setting),
        .alert_enable_low   (sw_out_a_ff[ALERT_EN_BIT]),
        .drive_value        (drive_value)
    ); // [R6] [R11] [R12]

    // Registered drive; status reads this, never the pin
    always_ff @(posedge sys_clk or negedge core_rstn) begin
        if (!core_rstn) begin
            drive_ff  <= {NUM_OUTPUTS{1'b1}};
            inputs_ff <= 4'h0;
        end else begin
            drive_ff  <= drive_value; // [R3]
            inputs_ff <= digital_input_pin;
        end
    end

    // Open drain: pull low for a zero, release for a one
    assign out_pin_o  = 14'h0000;
    assign out_pin_oe = ~drive_ff;

    // Input one has no override; others follow the nonvolatile mux
    assign logic_array_in = {
        input_mux_sel_reg[2] ? override_ff[2] : inputs_ff[3],
        input_mux_sel_reg[1] ? override_ff[1] : inputs_ff[2],
        input_mux_sel_reg[0] ? override_ff[0] : inputs_ff[1],
        inputs_ff[0]}; // [R17]

    // Read decode; unmapped offsets read all ones
    always_comb begin
        if (reg_addr == OFS_OUT_STATE_A) begin
            nxt_rdata = drive_ff[7:0]; // [R3] [R4]
        end else if (reg_addr == OFS_OUT_STATE_B) begin
            nxt_rdata = {2'b11, drive_ff[13:8]}; // [R5]
        end else if (reg_addr == OFS_INPUT_LEVELS) begin
            nxt_rdata = {4'hf, inputs_ff}; // [R1]
        end else if (reg_addr == OFS_SIG_A) begin
            nxt_rdata = user_signature[7:0]; // [R9]
        end else if (reg_addr == OFS_SIG_B) begin
            nxt_rdata = user_signature[15:8]; // [R9]
        end else if (reg_addr == OFS_SIG_C) begin
            nxt_rdata = user_signature[23:16]; // [R9]
        end else if (reg_addr == OFS_SIG_D) begin
            nxt_rdata = user_signature[31:24]; // [R9]
        end else if (reg_addr == OFS_SW_OUT_A) begin
            nxt_rdata = sw_out_a_ff; // [R7]
        end else if (reg_addr == OFS_SW_OUT_B) begin
            nxt_rdata = {2'b11, sw_out_b_ff}; // [R8] [R16]
        end else if (reg_addr == OFS_IN_OVERRIDE) begin
            nxt_rdata = {4'hf, override_ff, 1'b1}; // [R2] [R16]
        end else begin
            nxt_rdata = FILL_ONES;
        end
    end

    always_ff @(posedge sys_clk or negedge core_rstn) begin
        if (!core_rstn) begin
            rdata_ff <= FILL_ONES;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule

// ===== test/supv_bank_sva.sv
// Port assertions of the supervisor register bank
`timescale 1ns/1ps
module supv_bank_sva
    import supv_regs_pkg::*;
(
    input wire logic        sys_clk, rstn, reg_wr, reg_rd, ara_done,
    input wire logic        alert_mode_setting, device_rstn,
    input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
    input wire logic [6:0]  ara_sent_addr, own_slave_addr,
    input wire logic [13:0] output_src_sw, logic_array_out, out_pin_oe,
    input wire logic [31:0] user_signature
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!device_rstn);
    property p_in_hi;
        reg_rd && reg_addr == OFS_INPUT_LEVELS |=> reg_rdata[7:4] == 4'hf;
    endproperty
    a_in_hi: assert property (p_in_hi) else $error("input level pad");
    property p_ovr;
        reg_rd && reg_addr == OFS_IN_OVERRIDE |=> reg_rdata[7:4] == 4'hf
            && reg_rdata[0];
    endproperty
    a_ovr: assert property (p_ovr) else $error("override pad");
    property p_out_b;
        reg_rd && reg_addr == OFS_OUT_STATE_B |=> reg_rdata[7:6] == 2'b11;
    endproperty
    a_out_b: assert property (p_out_b) else $error("status pad");
    property p_sig;
        reg_rd && reg_addr == OFS_SIG_C |=> reg_rdata == user_signature[23:16];
    endproperty
    a_sig: assert property (p_sig) else $error("signature byte");
    property p_gp;
        (reg_wr && reg_addr == OFS_SW_OUT_A && !ara_done) ##1 !ara_done
            && !reg_wr ##1 (reg_rd && reg_addr == OFS_SW_OUT_A)
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_gp: assert property (p_gp) else $error("software bits readback");
    // Own reset only: the device reset is what is being checked
    property p_rst;
        disable iff (!rstn)
        reg_wr && reg_addr == OFS_SOFT_RESET |-> ##[1:5] !device_rstn;
    endproperty
    a_rst: assert property (p_rst) else $error("soft reset missing");
    property p_rel;
        ara_done && ara_sent_addr == own_slave_addr && alert_mode_setting
            && !output_src_sw[2] ##1 !reg_wr [*2] |-> ##[0:2] !out_pin_oe[2];
    endproperty
    a_rel: assert property (p_rel) else $error("alert not released");
    property p_arm;
        reg_wr && reg_addr == OFS_SW_OUT_A && !reg_wdata[2]
            && alert_mode_setting && !output_src_sw[2] ##1 (!ara_done
            && !reg_wr && !logic_array_out[2] && alert_mode_setting) [*3]
            |-> out_pin_oe[2];
    endproperty
    a_arm: assert property (p_arm) else $error("alert not pulled");
endmodule

bind supervisor_io_register_bank supv_bank_sva supv_bank_sva_i (.*);

// ===== test/supv_bus_master.sv
// Bus master and alert-response model on the register port
`timescale 1ns/1ps
module supv_bus_master (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr, reg_wdata,
    output logic            reg_wr, reg_rd, ara_done,
    output logic      [6:0] ara_sent_addr
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd, ara_done} = '0;
    initial ara_sent_addr = 7'h00;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        // Released data flips so a stale value never looks valid
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic ara(input logic [6:0] a);
        @(posedge sys_clk);
        {ara_sent_addr, ara_done} <= {a, 1'b1};
        @(posedge sys_clk);
        {ara_sent_addr, ara_done} <= {~a, 1'b0};
    endtask
endmodule

// ===== test/supervisor_io_register_bank_tb.sv
// Self-checking bench of the supervisor register bank
`timescale 1ns/1ps
module supervisor_io_register_bank_tb;
    import supv_regs_pkg::*;
    logic        sys_clk = 1'b0, rstn = 1'b0, alert_mode_setting = 1'b0;
    logic [3:0]  digital_input_pin = 4'h0, logic_array_in;
    logic [2:0]  input_mux_sel_reg = 3'h0;
    logic [13:0] output_src_sw = 14'h0, logic_array_out = 14'h0, d;
    logic [13:0] out_pin_o, out_pin_oe;
    logic [31:0] user_signature = 32'h0, r, lfsr = 32'd75593;
    logic [6:0]  own_slave_addr = 7'h2a, ara_sent_addr;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, a, b, ov, q;
    logic        reg_wr, reg_rd, ara_done, device_rstn;
    int          fail_count = 0, check_count = 0, n;
    supervisor_io_register_bank supervisor_io_register_bank_i (.*);
    supv_bus_master supv_bus_master_i (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [13:0] drv(logic [13:0] s, logic [7:0] x, y);
        return (s & {y[5:0], x}) | (~s & logic_array_out);
    endfunction
    function automatic logic [3:0] ain(logic [3:0] p, logic [2:0] s,
                                       logic [7:0] o);
        return {(s & o[3:1]) | (~s & p[3:1]), p[0]};
    endfunction
    task automatic mw(input logic [7:0] ad, dd); supv_bus_master_i.wr(ad, dd);
    endtask
    task automatic mr(input logic [7:0] ad); supv_bus_master_i.rd(ad, q);
    endtask
    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic alert_oe(input logic e);
        repeat (4) @(posedge sys_clk);
        chk(out_pin_oe[2], e);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        mr(OFS_SW_OUT_A); chk(q, 8'h04);
        mr(OFS_SW_OUT_B); chk(q, 8'hc0);
        mr(OFS_IN_OVERRIDE); chk(q, 8'hf1);
        mr(8'h05); chk(q, 8'hff);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            {a, b, ov} = r[23:0];
            r = rnd();
            digital_input_pin <= r[3:0];
            input_mux_sel_reg <= r[6:4];
            // Output three stays on the array outside alert mode
            output_src_sw <= r[20:7] & 14'h3ffb;
            logic_array_out <= r[31:18];
            user_signature <= rnd();
            mw(OFS_SW_OUT_A, a);
            mr(OFS_SW_OUT_A); chk(q, a);
            mw(OFS_SW_OUT_B, b);
            mw(OFS_IN_OVERRIDE, ov);
            mw(OFS_OUT_STATE_A, 8'h5a);
            mr(OFS_SW_OUT_B); chk(q, {2'b11, b[5:0]});
            mr(OFS_IN_OVERRIDE); chk(q, {4'hf, ov[3:1], 1'b1});
            mr(OFS_INPUT_LEVELS); chk(q, {4'hf, digital_input_pin});
            chk(logic_array_in, ain(digital_input_pin, input_mux_sel_reg, ov));
            d = drv(output_src_sw, a, b);
            mr(OFS_OUT_STATE_A); chk(q, d[7:0]);
            mr(OFS_OUT_STATE_B); chk(q, {2'b11, d[13:8]});
            chk({2'b00, out_pin_oe}, {2'b00, ~d});
            for (int j = 0; j < 4; j++) begin
                mr(8'(OFS_SIG_A + j)); chk(q, user_signature[8*j +: 8]);
            end
        end
        // Alert mode on, so output three follows the array and enable bit
        alert_mode_setting <= 1'b1;
        {output_src_sw, logic_array_out} <= '0;
        mw(OFS_SW_OUT_A, 8'h00);
        alert_oe(1'b1);
        supv_bus_master_i.ara(~own_slave_addr);
        alert_oe(1'b1);
        supv_bus_master_i.ara(own_slave_addr);
        alert_oe(1'b0);
        mr(OFS_SW_OUT_A); chk(q, 8'h04);
        mw(OFS_SW_OUT_A, 8'h00);
        alert_oe(1'b1);
        mw(OFS_SW_OUT_B, 8'h15);
        mw(OFS_SOFT_RESET, 8'h5a);
        for (n = 0; n < 30 && device_rstn !== 1'b0; n++) @(posedge sys_clk);
        for (; n < 30 && device_rstn !== 1'b1; n++) @(posedge sys_clk);
        if (n >= 30) fail_count++;
        repeat (2) @(posedge sys_clk);
        mr(OFS_SW_OUT_B); chk(q, 8'hc0);
        mr(OFS_SW_OUT_A); chk(q, 8'h04);
        results();
    end
endmodule
